/* File: dv/tb_ttm_txn_supervisor.sv */
// Self-checking bench of the transaction supervisor: APB, link stimulus and response queue.
`timescale 1ns/1ps
`include "ttm_defines.vh"
module tb_ttm_txn_supervisor;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, busReset = 0, respReady = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, txnOffsetLo = 32'h0;
  logic [3:0] pstrb = 4'hF, txnTCode = 4'h0, linkRespCode = 4'h0;
  logic [6:0] txnStart = 7'h0, linkAckValid = 7'h0, linkRespValid = 7'h0;
  logic [15:0] txnDestId = 16'h0, txnOffsetHi = 16'h0;
  logic [1:0] txnSpeed = 2'h0, linkAckCode = 2'h0;
  logic [5:0] txnLabel = 6'h0;
  wire [31:0] prdata;
  wire pready, pslverr, respValid, irq;
  wire [6:0] linkSendReq;
  wire [2:0] respTimer;
  wire [3:0] respStatus;
  int errCount = 0, totalChecks = 0, sendCount = 0, c;
  logic [64:0] rdq[$];
  logic [6:0] rsq[$];
  logic [64:0] e;
  logic [3:0] code;
  ttm_txn_supervisor #(.SPLIT_TIMEOUT_US(16'd2)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txnStart(txnStart),
    .txnDestId(txnDestId), .txnOffsetHi(txnOffsetHi), .txnOffsetLo(txnOffsetLo),
    .txnTCode(txnTCode), .txnSpeed(txnSpeed), .txnLabel(txnLabel), .linkSendReq(linkSendReq),
    .linkAckValid(linkAckValid), .linkAckCode(linkAckCode), .linkRespValid(linkRespValid),
    .linkRespCode(linkRespCode), .busReset(busReset), .respValid(respValid),
    .respTimer(respTimer), .respStatus(respStatus), .respReady(respReady), .irq(irq));
  initial forever #2 core_clk = ~core_clk;
  task endOfTest;
    if (errCount == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Reads carry {refused, mask, expected}; the monitor compares at the access edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= w ? d : ~d;
    if (!w) rdq.push_back({a < 8'h60 || a > 8'h74 || a[1:0] != 2'b00, m, d});
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
    psel <= 0; penable <= 0;
  endtask
  task automatic start(input int i);
    @(posedge core_clk);
    txnStart[i] <= 1; txnDestId <= $urandom; txnOffsetHi <= $urandom; txnOffsetLo <= $urandom;
    txnTCode <= $urandom; txnSpeed <= $urandom; txnLabel <= $urandom;
    @(posedge core_clk);
    txnStart[i] <= 0;
  endtask
  task automatic ack(input int i, input logic [1:0] k);
    int n;
    n = 0;
    do @(posedge core_clk); while (linkSendReq[i] !== 1'b1 && ++n < 300);
    cmp("linkSendReq", 1, n < 300);
    linkAckValid[i] <= 1; linkAckCode <= k;
    @(posedge core_clk);
    linkAckValid[i] <= 0; linkAckCode <= ~k;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (rsq.size() != 0 && n++ < 3000) @(posedge core_clk);
    cmp("pending responses", 0, rsq.size());
  endtask
  function logic [31:0] ctl(input logic [2:0] s, input logic [2:0] cmd);
    return {1'b0, cmd[2:0], 1'b0, s, 24'h0};
  endfunction
  always @(posedge core_clk) begin
    respReady <= $urandom % 2;
    if (linkSendReq[0] === 1'b1) sendCount++;
    if (!sys_rst && psel && penable && pready && !pwrite) begin
      e = rdq.pop_front();
      cmp("prdata", e[31:0], prdata & e[63:32]);
      cmp("pslverr", e[64], pslverr);
    end
    if (!sys_rst && respValid === 1'b1 && respReady) begin
      if (rsq.size() == 0) cmp("unexpected response", 0, {respTimer, respStatus});
      else cmp("response", rsq.pop_front(), {respTimer, respStatus});
    end
  end
  initial begin
    #80000;
    errCount++;
    endOfTest();
  end
  initial begin
    void'($urandom(32'h826f483d));
    repeat (16) @(posedge core_clk);
    sys_rst <= 0;
    apb(0, `TTM_OFF_CTRL, 32'h0000007F, 32'hFFFFFFFF);
    apb(0, 8'h50, 32'h0, 32'hFFFFFFFF);
    apb(1, `TTM_OFF_IRQ_MASK, 32'h7F, 0);
    start(4);
    ack(4, `TTM_ACK_COMPLETE);
    rsq.push_back({3'd4, `TTM_ST_OK});
    drain();
    apb(1, `TTM_OFF_CTRL, ctl(3'd4, 3'h0), 0);
    apb(0, `TTM_OFF_DEST_HI, {txnDestId, txnOffsetHi}, 32'hFFFFFFFF);
    apb(0, `TTM_OFF_DEST_LO, txnOffsetLo, 32'hFFFFFFFF);
    apb(0, `TTM_OFF_INFO, {txnTCode, txnSpeed, txnLabel, 4'h0, 16'h0}, 32'hFFFF0000);
    cmp("irq", 1, irq);
    apb(1, `TTM_OFF_IRQ_STAT, 32'h7F, 0);
    // The clear lands at the access edge, so irq is looked at once it has settled.
    @(negedge core_clk);
    cmp("irq", 0, irq);
    start(2);
    ack(2, `TTM_ACK_ERROR);
    rsq.push_back({3'd2, `TTM_ST_ACK_ERR});
    drain();
    apb(0, `TTM_OFF_CTRL, 32'h00000404, 32'h00000404);
    start(0);
    ack(0, `TTM_ACK_BUSY);
    apb(1, `TTM_OFF_CTRL, ctl(3'd0, 3'h2), 0);
    apb(0, `TTM_OFF_CTRL, 32'h00010000, 32'h00010001);
    c = sendCount;
    repeat (40) @(posedge core_clk);
    cmp("held sends", c, sendCount);
    apb(1, `TTM_OFF_CTRL, ctl(3'd0, 3'h4), 0);
    repeat (3) ack(0, `TTM_ACK_BUSY);
    rsq.push_back({3'd0, `TTM_ST_BUSY_RETRY});
    drain();
    start(1);
    ack(1, `TTM_ACK_PENDING);
    apb(0, `TTM_OFF_CTRL, 32'h0, 32'h00020002);
    rsq.push_back({3'd1, `TTM_ST_SPLIT_TIMEOUT});
    drain();
    start(3);
    ack(3, `TTM_ACK_PENDING);
    code = $urandom;
    repeat (5) @(posedge core_clk);
    linkRespValid[3] <= 1; linkRespCode <= code;
    @(posedge core_clk);
    linkRespValid[3] <= 0; linkRespCode <= ~code;
    rsq.push_back({3'd3, code});
    drain();
    start(6);
    ack(6, `TTM_ACK_PENDING);
    apb(1, `TTM_OFF_CTRL, ctl(3'd6, 3'h1), 0);
    apb(0, `TTM_OFF_CTRL, 32'h00004040, 32'h00404040);
    start(2);
    ack(2, `TTM_ACK_PENDING);
    busReset <= 1;
    @(posedge core_clk);
    busReset <= 0;
    apb(0, `TTM_OFF_CTRL, 32'h00000004, 32'h00040004);
    apb(1, `TTM_OFF_CTRL, ctl(3'd5, 3'h0), 0);
    apb(0, `TTM_OFF_INFO, 32'h0, 32'hFFFFFFFF);
    repeat (20) @(posedge core_clk);
    endOfTest();
  end
endmodule // tb_ttm_txn_supervisor

/* File: dv/ttm_txn_supervisor_props.sv */
// Port-level checks of the transaction supervisor, bound to its top module.
`timescale 1ns/1ps
`include "ttm_defines.vh"
module ttm_txn_supervisor_props (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [6:0] linkSendReq,
  input wire respValid,
  input wire [2:0] respTimer,
  input wire [3:0] respStatus,
  input wire respReady
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire mapped = (paddr == `TTM_OFF_CTRL) || (paddr == `TTM_OFF_DEST_HI) ||
    (paddr == `TTM_OFF_DEST_LO) || (paddr == `TTM_OFF_INFO) ||
    (paddr == `TTM_OFF_IRQ_STAT) || (paddr == `TTM_OFF_IRQ_MASK);
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_error: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_resp_hold: assert property (respValid && !respReady |=> respValid && $stable(respTimer)
    && $stable(respStatus)) else $error("response entry dropped before taken");
  a_resp_timer: assert property (respValid |-> respTimer != `TTM_TMR_UNUSED)
    else $error("response from unused timer");
  a_send_unused: assert property (linkSendReq[5] == 1'b0) else $error("unused timer sends");
  a_send_pulse: assert property (linkSendReq != 7'h0 |=> (linkSendReq & $past(linkSendReq)) == 7'h0)
    else $error("send request longer than one cycle");
  a_strobe_zero: assert property (psel && penable && !pwrite && paddr == `TTM_OFF_CTRL |->
    prdata[31:28] == 4'h0 && prdata[5]) else $error("control strobes or unused done bit wrong");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !respValid && linkSendReq == 7'h0
    && !pslverr) else $error("outputs active after reset");
  c_busy_end: cover property (respValid && respStatus == `TTM_ST_BUSY_RETRY);
  c_split_end: cover property (respValid && respStatus == `TTM_ST_SPLIT_TIMEOUT);
  c_refused: cover property (pslverr);
endmodule // ttm_txn_supervisor_props
bind ttm_txn_supervisor ttm_txn_supervisor_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .linkSendReq(linkSendReq), .respValid(respValid), .respTimer(respTimer),
  .respStatus(respStatus), .respReady(respReady));

/* File: hdl/ttm_resp_arbiter.v */
// Picks one finished timer at a time and loads its status into the response output stage.
`timescale 1ns/1ps
module ttm_resp_arbiter #(
  parameter N = 7
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [N-1:0] pend,
  input wire [4*N-1:0] statusFlat,
  input wire respReady,
  output reg respValid,
  output reg [2:0] respTimer,
  output reg [3:0] respStatus,
  output reg [N-1:0] take
);
  integer i;
  reg found;

  always @* begin
    take = {N{1'b0}};
    found = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (pend[i] && !found && (!respValid || respReady)) begin
        take[i] = 1'b1;
        found = 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      respValid <= 1'b0;
      respTimer <= 3'h0;
      respStatus <= 4'h0;
    end else begin
      if (respReady) begin
        respValid <= 1'b0;
      end
      for (i = 0; i < N; i = i + 1) begin
        if (take[i]) begin
          respValid <= 1'b1;
          respTimer <= i[2:0];
          respStatus <= statusFlat[4*i +: 4];
        end
      end
    end
  end
endmodule // ttm_resp_arbiter

/* File: hdl/ttm_timer_slot.v */
// One transaction timer: send, acknowledge, busy retry, split wait, hold and abort.
`timescale 1ns/1ps
`include "ttm_defines.vh"
module ttm_timer_slot #(
  parameter [3:0] MAX_RETRY = `TTM_MAX_RETRY,
  parameter [15:0] SPLIT_LIMIT = `TTM_SPLIT_TIMEOUT_US,
  parameter [7:0] GAP_CYCLES = 8'd10
) (
  input wire core_clk,
  input wire sys_rst,
  input wire tick,
  input wire start,
  input wire ackValid,
  input wire [1:0] ackCode,
  input wire respIn,
  input wire [3:0] respCode,
  input wire abortCmd,
  input wire holdCmd,
  input wire releaseCmd,
  input wire busReset,
  input wire respTake,
  output reg sendReq,
  output reg done,
  output reg fault,
  output wire retrying,
  output reg [3:0] retryCount,
  output reg [15:0] splitTimer,
  output reg respPend,
  output reg [3:0] respStatus
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SEND = 3'd1;
  localparam [2:0] ST_ACKW = 3'd2;
  localparam [2:0] ST_GAP = 3'd3;
  localparam [2:0] ST_SPLIT = 3'd4;
  localparam [2:0] ST_HELD = 3'd5;

  reg [2:0] state;
  reg [2:0] heldState;
  reg [7:0] gapCount;
  reg finish;
  reg [3:0] finishStatus;

  // A split wait never reports retrying; the other active states do once a busy retry has been counted.
  assign retrying = (retryCount != 4'h0) && (state == ST_SEND || state == ST_ACKW ||
    state == ST_GAP || (state == ST_HELD && heldState != ST_SPLIT)); // R7 R8

  always @* begin
    finish = 1'b0;
    finishStatus = `TTM_ST_OK;
    if (state == ST_ACKW && ackValid) begin
      case (ackCode)
        `TTM_ACK_COMPLETE: finish = 1'b1;
        `TTM_ACK_ERROR: begin
          finish = 1'b1;
          finishStatus = `TTM_ST_ACK_ERR;
        end
        `TTM_ACK_BUSY: begin
          finish = (retryCount == MAX_RETRY);
          finishStatus = `TTM_ST_BUSY_RETRY; // R5
        end
        default: finish = 1'b0;
      endcase
    end else if (state == ST_SPLIT && respIn) begin
      finish = 1'b1;
      finishStatus = respCode; // R4
    end else if (state == ST_SPLIT && splitTimer == SPLIT_LIMIT) begin
      finish = 1'b1;
      finishStatus = `TTM_ST_SPLIT_TIMEOUT; // R5
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      heldState <= ST_IDLE;
      gapCount <= 8'h00;
      sendReq <= 1'b0;
      done <= 1'b1;
      fault <= 1'b0;
      retryCount <= 4'h0;
      splitTimer <= 16'h0000;
      respPend <= 1'b0;
      respStatus <= `TTM_ST_OK;
    end else begin
      sendReq <= (state == ST_SEND);
      if (respTake) begin
        respPend <= 1'b0;
      end
      if (busReset || (abortCmd && state != ST_IDLE)) begin
        // Discarded work leaves no response entry behind.
        state <= ST_IDLE; // R6 R11
        done <= 1'b1;
        fault <= 1'b1;
      end else if (holdCmd && state != ST_IDLE && state != ST_HELD) begin
        heldState <= state; // R12
        state <= ST_HELD;
      end else if (finish) begin
        state <= ST_IDLE; // R1
        done <= 1'b1; // R2
        fault <= (finishStatus != `TTM_ST_OK); // R3
        respPend <= 1'b1; // R4
        respStatus <= finishStatus;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start) begin
              state <= ST_SEND; // R1
              done <= 1'b0; // R2
              retryCount <= 4'h0;
              splitTimer <= 16'h0000;
            end
          end
          ST_SEND: state <= ST_ACKW;
          ST_ACKW: begin
            if (ackValid && ackCode == `TTM_ACK_PENDING) begin
              state <= ST_SPLIT;
              splitTimer <= 16'h0000;
            end else if (ackValid && ackCode == `TTM_ACK_BUSY) begin
              retryCount <= retryCount + 4'h1;
              gapCount <= 8'h00;
              state <= ST_GAP;
            end
          end
          ST_GAP: begin
            gapCount <= gapCount + 8'h01;
            if (gapCount == GAP_CYCLES - 8'h01) begin
              state <= ST_SEND;
            end
          end
          ST_SPLIT: begin
            if (tick) begin
              splitTimer <= splitTimer + 16'h0001;
            end
          end
          ST_HELD: begin
            if (releaseCmd) begin
              state <= heldState; // R13
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // ttm_timer_slot

/* File: hdl/ttm_txn_supervisor.v */
// Transaction supervisor top: timers, APB registers, timer selection, response output, interrupt.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ttm_defines.vh"
// Function
// R1: After hand-off each timer runs its transaction to the end without software help.
// R2: Per-timer done flag in control reads low while busy, high when finished.
// R3: Per-timer fault flag set when the last transaction ended in error.
// R4: Every finished transaction pushes a response entry with its status.
// R5: Exhausted busy retries or split timeout still push a substitute status entry.
// R6: Aborted or bus-reset transactions push no response entry.
// R7: Per-timer retry flag is high while the transaction is active and retrying.
// R8: Retry clear with done still low means the timer waits in a split; the code also reads so on the first attempt, before any busy acknowledge.
// R9: Selected timer's destination, label, speed and retry count show in status words.
// R10: Timer numbers: 0,1,2,3,4,6 for the six queues; 5 is unused.
// R11: Abort bit with a selected timer terminates that timer's transaction.
// R12: Hold bit suspends the selected timer's transaction until released.
// R13: Release bit resumes a transaction suspended by hold.
// R14: Third status word gives code, speed, label, retry count and split timer.
// R15: Abort, hold and release are one-cycle strobes that read back as zero.
module ttm_txn_supervisor #(
  parameter [3:0] MAX_RETRY = `TTM_MAX_RETRY,
  parameter [15:0] SPLIT_TIMEOUT_US = `TTM_SPLIT_TIMEOUT_US
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [6:0] txnStart,
  input wire [15:0] txnDestId,
  input wire [15:0] txnOffsetHi,
  input wire [31:0] txnOffsetLo,
  input wire [3:0] txnTCode,
  input wire [1:0] txnSpeed,
  input wire [5:0] txnLabel,
  output wire [6:0] linkSendReq,
  input wire [6:0] linkAckValid,
  input wire [1:0] linkAckCode,
  input wire [6:0] linkRespValid,
  input wire [3:0] linkRespCode,
  input wire busReset,
  output wire respValid,
  output wire [2:0] respTimer,
  output wire [3:0] respStatus,
  input wire respReady,
  output wire irq
);
  localparam NT = `TTM_NUM_TIMERS;
  localparam integer TICK_CYCLES = `TTM_TICK_NS / `TTM_CLK_PERIOD_NS;
  localparam integer GAP_CYC_INT =
    (`TTM_RETRY_GAP_NS + `TTM_CLK_PERIOD_NS - 1) / `TTM_CLK_PERIOD_NS;
  localparam [7:0] GAP_CYCLES = GAP_CYC_INT[7:0];
  localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
  localparam [9:0] TICK_LAST = TICK_LAST_INT[9:0];

  // Timer 5 has no queue behind it and is kept permanently idle.
  function slotUsed;
    input integer idx;
    begin
      slotUsed = (idx != `TTM_TMR_UNUSED); // R10
    end
  endfunction

  function [31:0] maskLanes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] strb;
    integer b;
    begin
      maskLanes = oldVal;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          maskLanes[8*b +: 8] = newVal[8*b +: 8];
        end
      end
    end
  endfunction

  // Microsecond time base for the split timers.
  reg [9:0] tickCount;
  reg tick;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tickCount <= 10'h000;
      tick <= 1'b0;
    end else begin
      tick <= (tickCount == TICK_LAST);
      if (tickCount == TICK_LAST) begin
        tickCount <= 10'h000;
      end else begin
        tickCount <= tickCount + 10'h001;
      end
    end
  end

  // APB decode. The slave never waits, so pready is high in every access phase.
  wire setupPhase = psel && !penable;
  wire accessPhase = psel && penable;
  wire wrAccess = accessPhase && pwrite;
  wire hitCtrl = (paddr == `TTM_OFF_CTRL);
  wire hitStat = (paddr == `TTM_OFF_IRQ_STAT);
  wire hitMask = (paddr == `TTM_OFF_IRQ_MASK);
  wire mapped = hitCtrl || hitStat || hitMask || (paddr == `TTM_OFF_DEST_HI) ||
    (paddr == `TTM_OFF_DEST_LO) || (paddr == `TTM_OFF_INFO);
  assign pready = 1'b1;

  reg [2:0] timerSelect;
  reg [6:0] irqStatus;
  reg [6:0] irqMask;
  reg abortCmd;
  reg holdCmd;
  reg releaseCmd;

  wire [31:0] ctrlWrite = maskLanes(32'h00000000, pwdata, pstrb);
  wire ctrlWe = wrAccess && hitCtrl;

  // Command strobes live one cycle and are never stored in the register.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      timerSelect <= `TTM_SEL_RESET;
      abortCmd <= 1'b0;
      holdCmd <= 1'b0;
      releaseCmd <= 1'b0;
    end else begin
      abortCmd <= ctrlWe && ctrlWrite[`TTM_CTRL_ABORT_BIT]; // R15
      holdCmd <= ctrlWe && ctrlWrite[`TTM_CTRL_HOLD_BIT]; // R15
      releaseCmd <= ctrlWe && ctrlWrite[`TTM_CTRL_RELEASE_BIT]; // R15
      if (ctrlWe && pstrb[3]) begin
        timerSelect <= pwdata[`TTM_CTRL_SEL_LSB +: 3]; // R9
      end
    end
  end

  // Strobes are taken one cycle after the write, after timerSelect has updated.
  // A write that changes the selection and commands together acts on the new number.
  wire [6:0] selOneHot = 7'h01 << timerSelect;

  wire [6:0] slotDone;
  wire [6:0] slotFault;
  wire [6:0] slotRetry;
  wire [6:0] slotPend;
  wire [6:0] slotTake;
  wire [27:0] slotStatusFlat;
  wire [27:0] slotRetryCountFlat;
  wire [111:0] slotSplitFlat;

  reg [15:0] capDestId [0:NT-1];
  reg [15:0] capOffsetHi [0:NT-1];
  reg [31:0] capOffsetLo [0:NT-1];
  reg [3:0] capTCode [0:NT-1];
  reg [1:0] capSpeed [0:NT-1];
  reg [5:0] capLabel [0:NT-1];

  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : gen_timer
      if (slotUsed(g)) begin : gen_live
        // Header fields are kept for status reads while the timer runs.
        always @(posedge core_clk) begin
          if (sys_rst) begin
            capDestId[g] <= 16'h0000;
            capOffsetHi[g] <= 16'h0000;
            capOffsetLo[g] <= 32'h00000000;
            capTCode[g] <= 4'h0;
            capSpeed[g] <= 2'h0;
            capLabel[g] <= 6'h00;
          end else if (txnStart[g] && slotDone[g]) begin
            capDestId[g] <= txnDestId;
            capOffsetHi[g] <= txnOffsetHi;
            capOffsetLo[g] <= txnOffsetLo;
            capTCode[g] <= txnTCode;
            capSpeed[g] <= txnSpeed;
            capLabel[g] <= txnLabel;
          end
        end

        ttm_timer_slot #(
          .MAX_RETRY(MAX_RETRY),
          .SPLIT_LIMIT(SPLIT_TIMEOUT_US),
          .GAP_CYCLES(GAP_CYCLES)
        ) u_slot (
          .core_clk(core_clk),
          .sys_rst(sys_rst),
          .tick(tick),
          .start(txnStart[g]),
          .ackValid(linkAckValid[g]),
          .ackCode(linkAckCode),
          .respIn(linkRespValid[g]),
          .respCode(linkRespCode),
          .abortCmd(abortCmd && selOneHot[g]), // R11
          .holdCmd(holdCmd && selOneHot[g]), // R12
          .releaseCmd(releaseCmd && selOneHot[g]), // R13
          .busReset(busReset), // R6
          .respTake(slotTake[g]),
          .sendReq(linkSendReq[g]),
          .done(slotDone[g]),
          .fault(slotFault[g]),
          .retrying(slotRetry[g]),
          .retryCount(slotRetryCountFlat[4*g +: 4]),
          .splitTimer(slotSplitFlat[16*g +: 16]),
          .respPend(slotPend[g]),
          .respStatus(slotStatusFlat[4*g +: 4])
        );
      end else begin : gen_idle
        always @(posedge core_clk) begin
          capDestId[g] <= 16'h0000;
          capOffsetHi[g] <= 16'h0000;
          capOffsetLo[g] <= 32'h00000000;
          capTCode[g] <= 4'h0;
          capSpeed[g] <= 2'h0;
          capLabel[g] <= 6'h00;
        end
        assign linkSendReq[g] = 1'b0;
        assign slotDone[g] = 1'b1;
        assign slotFault[g] = 1'b0;
        assign slotRetry[g] = 1'b0;
        assign slotPend[g] = 1'b0;
        assign slotRetryCountFlat[4*g +: 4] = 4'h0;
        assign slotSplitFlat[16*g +: 16] = 16'h0000;
        assign slotStatusFlat[4*g +: 4] = 4'h0;
      end
    end
  endgenerate

  ttm_resp_arbiter #(
    .N(NT)
  ) u_resp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pend(slotPend),
    .statusFlat(slotStatusFlat),
    .respReady(respReady),
    .respValid(respValid), // R4
    .respTimer(respTimer),
    .respStatus(respStatus),
    .take(slotTake)
  );

  // Interrupt: the end of each transaction is sticky until software writes a one.
  reg [6:0] doneLast;
  wire [6:0] doneRise = slotDone & ~doneLast;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      doneLast <= 7'h7F;
      irqStatus <= 7'h00;
      irqMask <= 7'h00;
    end else begin
      doneLast <= slotDone;
      if (wrAccess && hitMask && pstrb[0]) begin
        irqMask <= pwdata[6:0];
      end
      // A new event in the clearing cycle survives the clear.
      if (wrAccess && hitStat && pstrb[0]) begin
        irqStatus <= (irqStatus & ~pwdata[6:0]) | doneRise;
      end else begin
        irqStatus <= irqStatus | doneRise;
      end
    end
  end
  assign irq = |(irqStatus & irqMask);

  // Read data is built in the setup phase so it comes from a flip-flop.
  wire [2:0] sel = timerSelect;
  wire [31:0] ctrlRead = ({25'h0, slotDone} << `TTM_CTRL_DONE_LSB) | // R2
    ({25'h0, slotFault} << `TTM_CTRL_FAULT_LSB) | // R3
    ({25'h0, slotRetry} << `TTM_CTRL_RETRY_LSB) | // R7 R8
    ({29'h0, timerSelect} << `TTM_CTRL_SEL_LSB);
  wire [31:0] destHiRead = {capDestId[sel], capOffsetHi[sel]}; // R9
  wire [31:0] destLoRead = capOffsetLo[sel]; // R9
  wire [31:0] infoRead = {capTCode[sel], capSpeed[sel], capLabel[sel],
    slotRetryCountFlat[4*sel +: 4], slotSplitFlat[16*sel +: 16]}; // R14

  always @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !mapped;
      case (paddr)
        `TTM_OFF_CTRL: prdata <= ctrlRead;
        `TTM_OFF_DEST_HI: prdata <= destHiRead;
        `TTM_OFF_DEST_LO: prdata <= destLoRead;
        `TTM_OFF_INFO: prdata <= infoRead;
        `TTM_OFF_IRQ_STAT: prdata <= {25'h0, irqStatus};
        `TTM_OFF_IRQ_MASK: prdata <= {25'h0, irqMask};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ttm_txn_supervisor

/* File: pkg/ttm_defines.vh */
// Register offsets, field positions, codes and timing constants of the transaction supervisor.
`ifndef TTM_DEFINES_VH
`define TTM_DEFINES_VH

`define TTM_ADDR_W 8
`define TTM_OFF_CTRL 8'h60
`define TTM_OFF_DEST_HI 8'h64
`define TTM_OFF_DEST_LO 8'h68
`define TTM_OFF_INFO 8'h6C
`define TTM_OFF_IRQ_STAT 8'h70
`define TTM_OFF_IRQ_MASK 8'h74

`define TTM_NUM_TIMERS 7
`define TTM_CTRL_DONE_LSB 0
`define TTM_CTRL_FAULT_LSB 8
`define TTM_CTRL_RETRY_LSB 16
`define TTM_CTRL_SEL_LSB 24
`define TTM_CTRL_ABORT_BIT 28
`define TTM_CTRL_HOLD_BIT 29
`define TTM_CTRL_RELEASE_BIT 30
`define TTM_SEL_RESET 3'h0

`define TTM_TMR_DATA_OUT 3'h0
`define TTM_TMR_DATA_IN 3'h1
`define TTM_TMR_ASYNC_OUT 3'h2
`define TTM_TMR_MGMT 3'h3
`define TTM_TMR_CMD 3'h4
`define TTM_TMR_UNUSED 3'h5
`define TTM_TMR_ASYNC_RESP 3'h6

`define TTM_ACK_COMPLETE 2'h0
`define TTM_ACK_PENDING 2'h1
`define TTM_ACK_BUSY 2'h2
`define TTM_ACK_ERROR 2'h3

`define TTM_ST_OK 4'h0
`define TTM_ST_ACK_ERR 4'hD
`define TTM_ST_BUSY_RETRY 4'hE
`define TTM_ST_SPLIT_TIMEOUT 4'hF

`define TTM_CLK_PERIOD_NS 4
`define TTM_TICK_NS 1000
`define TTM_RETRY_GAP_NS 40
`define TTM_SPLIT_TIMEOUT_US 16'd100
`define TTM_MAX_RETRY 4'd3

`endif
